// ===== logic/ptf_regs.svh
`ifndef PTF_REGS_SVH
`define PTF_REGS_SVH
// system clock period, ns
`define PTF_CLK_PERIOD_NS 10
// mac clock periods, ns; each mac rate is a tick every (period / clock period) cycles
`define PTF_TX_MAC_PERIOD_NS 40
`define PTF_RX_MAC_PERIOD_NS 40
// time field layout: wide = seconds | ns | fraction, narrow = ns | fraction
`define PTF_FRAC_W 16
`define PTF_WIDE_SEC_LSB 48
`define PTF_NS_PER_SEC 32'h3b9aca00
// reset values of the time counters
`define PTF_WIDE_RESET 96'h0
`define PTF_NARROW_RESET 64'h0
// period trim applied by a steering synchronizer, ns scaled by 2^16
`define PTF_TRIM_STEP_FX 32'h00000100
// error beyond which a slave is reloaded instead of steered, ns
`define PTF_LOCK_LIMIT_NS 48'h000000000064
`endif

// ===== logic/ptf_pkg.sv
package ptf_pkg;
   typedef logic [95:0] ptf_wide_t;
   typedef logic [63:0] ptf_narrow_t;
   typedef enum {ptf_fmt_wide, ptf_fmt_narrow, ptf_fmt_both} ptf_format_t;
   typedef enum {ptf_topo_tx_master, ptf_topo_shared_master} ptf_topo_t;
   typedef enum {ptf_st_hunt, ptf_st_track} ptf_sync_state_t;
endpackage

// ===== logic/ptf_time_if.sv
`timescale 1ns/1ps
interface ptf_time_if;
   // mac period enables and resets from the core
   logic tx_mac_tick;
   logic rx_mac_tick;
   logic csr_rst_n;
   logic tx_rst_n;
   logic rx_rst_n;
   // current time into the core
   ptf_pkg::ptf_wide_t core_tx_time_wide_in;
   ptf_pkg::ptf_narrow_t core_tx_time_narrow_in;
   ptf_pkg::ptf_wide_t core_rx_time_wide_in;
   ptf_pkg::ptf_narrow_t core_rx_time_narrow_in;

   modport core_end (
      output tx_mac_tick, rx_mac_tick, csr_rst_n, tx_rst_n, rx_rst_n,
      input core_tx_time_wide_in, core_tx_time_narrow_in,
      input core_rx_time_wide_in, core_rx_time_narrow_in
   );
   modport time_end (
      input tx_mac_tick, rx_mac_tick, csr_rst_n, tx_rst_n, rx_rst_n,
      output core_tx_time_wide_in, core_tx_time_narrow_in,
      output core_rx_time_wide_in, core_rx_time_narrow_in
   );
endinterface // ptf_time_if

// ===== logic/ptf_time_counter.sv
`timescale 1ns/1ps
`include "ptf_regs.svh"
module ptf_time_counter #(
   parameter logic [31:0] PERIOD_FX = 32'h00280000
)(
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic period_rst_n,
   // period enable and steering
   input wire logic tick,
   input wire logic signed [1:0] trim_wide,
   input wire logic signed [1:0] trim_narrow,
   // hard loads, taken on a tick
   input wire logic load_wide,
   input wire ptf_pkg::ptf_wide_t load_wide_val,
   input wire logic load_narrow,
   input wire ptf_pkg::ptf_narrow_t load_narrow_val,
   // current time
   output ptf_pkg::ptf_wide_t counter_time_wide_out,
   output ptf_pkg::ptf_narrow_t counter_time_narrow_out
);
   import ptf_pkg::*;

   logic signed [1:0] trim_w_q;
   logic signed [1:0] trim_n_q;
   ptf_wide_t wide_q;
   ptf_wide_t wide_d;
   ptf_wide_t base_w;
   ptf_narrow_t narrow_q;
   ptf_narrow_t narrow_d;
   ptf_narrow_t base_n;
   logic [48:0] sum_w;

   // nominal period moved one step by the trim sign
   function automatic logic [31:0] trimmed(input logic signed [1:0] t);
      if (t == 2'sh1)
         return PERIOD_FX + `PTF_TRIM_STEP_FX;
      else if (t[1])
         return PERIOD_FX - `PTF_TRIM_STEP_FX;
      else
         return PERIOD_FX;
   endfunction

   // steering trims, back to nominal on the period reset
   always_ff @(posedge sys_clk)
   begin
      if (!period_rst_n)
      begin
         trim_w_q <= 2'sh0;
         trim_n_q <= 2'sh0;
      end
      else if (tick)
      begin
         trim_w_q <= trim_wide;
         trim_n_q <= trim_narrow;
      end
   end

   // next time: ns rolls into seconds at one second in the wide layout
   always_comb
   begin
      base_w = load_wide ? load_wide_val : wide_q;
      sum_w = {1'b0, base_w[47:0]} + {17'h0, trimmed(trim_w_q)};
      wide_d = {base_w[95:`PTF_WIDE_SEC_LSB], sum_w[47:0]};
      if (sum_w[48:`PTF_FRAC_W] >= {1'b0, `PTF_NS_PER_SEC})
      begin
         wide_d[47:`PTF_FRAC_W] = 32'(sum_w[48:`PTF_FRAC_W] - {1'b0, `PTF_NS_PER_SEC});
         wide_d[95:`PTF_WIDE_SEC_LSB] = base_w[95:`PTF_WIDE_SEC_LSB] + 48'h1;
      end
      base_n = load_narrow ? load_narrow_val : narrow_q;
      narrow_d = base_n + {32'h0, trimmed(trim_n_q)};
   end

   // time registers advance on every period tick
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wide_q <= `PTF_WIDE_RESET;
         narrow_q <= `PTF_NARROW_RESET;
      end
      else if (tick)
      begin
         wide_q <= wide_d;
         narrow_q <= narrow_d;
      end
   end

   assign counter_time_wide_out = wide_q;
   assign counter_time_narrow_out = narrow_q;
endmodule // ptf_time_counter

// ===== logic/ptf_mac_time_port.sv
`timescale 1ns/1ps
`include "ptf_regs.svh"
module ptf_mac_time_port #(
   parameter ptf_pkg::ptf_format_t FORMAT = ptf_pkg::ptf_fmt_both
)(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // link to the time source
   ptf_time_if.core_end link,
   // reset requests from pins
   input wire logic csr_rst_req_n,
   input wire logic tx_rst_req_n,
   input wire logic rx_rst_req_n,
   // sampled time per path
   output ptf_pkg::ptf_wide_t tx_time_wide,
   output ptf_pkg::ptf_narrow_t tx_time_narrow,
   output ptf_pkg::ptf_wide_t rx_time_wide,
   output ptf_pkg::ptf_narrow_t rx_time_narrow,
   // sample strobes and stall flags
   output logic tx_time_fresh,
   output logic rx_time_fresh,
   output logic tx_time_stuck,
   output logic rx_time_stuck
);
   import ptf_pkg::*;

   localparam logic HAS_W = (FORMAT != ptf_fmt_narrow);
   localparam logic HAS_N = (FORMAT != ptf_fmt_wide);
   localparam int TX_DIV = `PTF_TX_MAC_PERIOD_NS / `PTF_CLK_PERIOD_NS;
   localparam int RX_DIV = `PTF_RX_MAC_PERIOD_NS / `PTF_CLK_PERIOD_NS;

   logic [2:0] req_n;
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] rst_n_q;
   logic [7:0] div_q [2];
   logic tick_q [2];
   ptf_wide_t win [2];
   ptf_narrow_t nin [2];
   ptf_wide_t w_q [2];
   ptf_narrow_t n_q [2];
   logic fresh_q [2];
   logic stuck_q [2];

   assign req_n = {rx_rst_req_n, tx_rst_req_n, csr_rst_req_n};
   assign win[0] = link.core_tx_time_wide_in;
   assign nin[0] = link.core_tx_time_narrow_in;
   assign win[1] = link.core_rx_time_wide_in;
   assign nin[1] = link.core_rx_time_narrow_in;

   // pin reset requests pass three flops, then become the core resets
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         rst_n_q <= 3'h0;
      end
      else
      begin
         meta_q <= req_n;
         sync_q <= meta_q;
         rst_n_q <= sync_q;
      end
   end

   assign link.csr_rst_n = rst_n_q[0];
   assign link.tx_rst_n = rst_n_q[1];
   assign link.rx_rst_n = rst_n_q[2];

   // per path: mac period divider and time sampling
   for (genvar p = 0; p < 2; p++)
   begin : g_path
      localparam int DIV = (p == 0) ? TX_DIV : RX_DIV;
      // mac period enable
      always_ff @(posedge sys_clk)
      begin
         if (!nrst)
         begin
            div_q[p] <= 8'h0;
            tick_q[p] <= 1'b0;
         end
         else
         begin
            div_q[p] <= (div_q[p] == 8'(DIV - 1)) ? 8'h0 : div_q[p] + 8'h1;
            tick_q[p] <= (div_q[p] == 8'(DIV - 1));
         end
      end
      // sample only the formats the core is built for
      always_ff @(posedge sys_clk)
      begin
         if (!nrst || !rst_n_q[p + 1])
         begin
            w_q[p] <= `PTF_WIDE_RESET;
            n_q[p] <= `PTF_NARROW_RESET;
            fresh_q[p] <= 1'b0;
            stuck_q[p] <= 1'b0;
         end
         else
         begin
            fresh_q[p] <= tick_q[p];
            if (tick_q[p])
            begin
               w_q[p] <= HAS_W ? win[p] : `PTF_WIDE_RESET;
               n_q[p] <= HAS_N ? nin[p] : `PTF_NARROW_RESET;
               stuck_q[p] <= (HAS_W && win[p] == w_q[p]) || (HAS_N && nin[p] == n_q[p]);
            end
         end
      end
   end

   assign link.tx_mac_tick = tick_q[0];
   assign link.rx_mac_tick = tick_q[1];
   assign tx_time_wide = w_q[0];
   assign tx_time_narrow = n_q[0];
   assign rx_time_wide = w_q[1];
   assign rx_time_narrow = n_q[1];
   assign tx_time_fresh = fresh_q[0];
   assign rx_time_fresh = fresh_q[1];
   assign tx_time_stuck = stuck_q[0];
   assign rx_time_stuck = stuck_q[1];
endmodule // ptf_mac_time_port

// ===== logic/ptf_time_source.sv
`timescale 1ns/1ps
`include "ptf_regs.svh"
module ptf_time_source #(
   parameter ptf_pkg::ptf_format_t FORMAT = ptf_pkg::ptf_fmt_both,
   parameter ptf_pkg::ptf_topo_t TOPOLOGY = ptf_pkg::ptf_topo_tx_master
)(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // link to the core
   ptf_time_if.time_end link,
   // master time set from user logic
   input wire logic set_time,
   input wire ptf_pkg::ptf_wide_t set_wide,
   input wire ptf_pkg::ptf_narrow_t set_narrow,
   // synchronizer status, index slave*2 + format (0 wide, 1 narrow)
   output logic [3:0] sync_locked,
   output logic [3:0] sync_lock_lost,
   // master time
   output ptf_pkg::ptf_wide_t master_time_wide,
   output ptf_pkg::ptf_narrow_t master_time_narrow
);
   import ptf_pkg::*;

   localparam int NCNT = 3;
   localparam logic SHARED = (TOPOLOGY == ptf_topo_shared_master);
   localparam logic HAS_W = (FORMAT != ptf_fmt_narrow);
   localparam logic HAS_N = (FORMAT != ptf_fmt_wide);
   // counter 0 is tx, 1 is rx, 2 the shared master
   localparam int MI = SHARED ? 2 : 0;
   localparam logic [31:0] TX_PER_FX = 32'(`PTF_TX_MAC_PERIOD_NS) << `PTF_FRAC_W;
   localparam logic [31:0] RX_PER_FX = 32'(`PTF_RX_MAC_PERIOD_NS) << `PTF_FRAC_W;

   ptf_wide_t cnt_w [NCNT];
   ptf_narrow_t cnt_n [NCNT];
   logic tick [NCNT];
   logic ld_w [NCNT];
   logic ld_n [NCNT];
   ptf_wide_t ldv_w [NCNT];
   ptf_narrow_t ldv_n [NCNT];
   logic signed [1:0] tr_w [NCNT];
   logic signed [1:0] tr_n [NCNT];
   logic sld_w [2];
   logic sld_n [2];
   logic signed [1:0] str_w [2];
   logic signed [1:0] str_n [2];
   logic set_pend_q;
   ptf_wide_t set_w_q;
   ptf_narrow_t set_n_q;
   logic gen_rst_n;

   // general counter reset tied to the core's csr reset
   assign gen_rst_n = nrst & link.csr_rst_n;

   // master set request held until the master's next tick; a new request wins
   always_ff @(posedge sys_clk)
   begin
      if (!gen_rst_n)
      begin
         set_pend_q <= 1'b0;
         set_w_q <= `PTF_WIDE_RESET;
         set_n_q <= `PTF_NARROW_RESET;
      end
      else if (set_time)
      begin
         set_pend_q <= 1'b1;
         set_w_q <= set_wide;
         set_n_q <= set_narrow;
      end
      else if (tick[MI])
      begin
         set_pend_q <= 1'b0;
      end
   end

   // time counters: tx, rx and, with a shared master, the master itself
   for (genvar c = 0; c < NCNT; c++)
   begin : g_cnt
      localparam logic [31:0] PER = (c == 1) ? RX_PER_FX : TX_PER_FX;
      assign tick[c] = (c == 1) ? link.rx_mac_tick : link.tx_mac_tick;
      if (c == MI)
      begin : g_master
         assign ld_w[c] = set_pend_q;
         assign ld_n[c] = set_pend_q;
         assign ldv_w[c] = set_w_q;
         assign ldv_n[c] = set_n_q;
         assign tr_w[c] = 2'sh0;
         assign tr_n[c] = 2'sh0;
      end
      else if (c < 2)
      begin : g_slave
         assign ld_w[c] = sld_w[c];
         assign ld_n[c] = sld_n[c];
         assign ldv_w[c] = cnt_w[MI];
         assign ldv_n[c] = cnt_n[MI];
         assign tr_w[c] = str_w[c];
         assign tr_n[c] = str_n[c];
      end
      else
      begin : g_unused
         assign ld_w[c] = 1'b0;
         assign ld_n[c] = 1'b0;
         assign ldv_w[c] = `PTF_WIDE_RESET;
         assign ldv_n[c] = `PTF_NARROW_RESET;
         assign tr_w[c] = 2'sh0;
         assign tr_n[c] = 2'sh0;
      end
      if (c < 2 || SHARED)
      begin : g_inst
         ptf_time_counter #(
            .PERIOD_FX(PER)
         ) u_cnt (
            .sys_clk(sys_clk),
            .rst_n(gen_rst_n),
            .period_rst_n((c == 1) ? link.rx_rst_n : link.tx_rst_n),
            .tick(tick[c]),
            .trim_wide(tr_w[c]),
            .trim_narrow(tr_n[c]),
            .load_wide(ld_w[c]),
            .load_wide_val(ldv_w[c]),
            .load_narrow(ld_n[c]),
            .load_narrow_val(ldv_n[c]),
            .counter_time_wide_out(cnt_w[c]),
            .counter_time_narrow_out(cnt_n[c])
         );
      end
      else
      begin : g_none
         assign cnt_w[c] = `PTF_WIDE_RESET;
         assign cnt_n[c] = `PTF_NARROW_RESET;
      end
   end

   // synchronizers: one per slave counter and per format in use
   for (genvar c = 0; c < 2; c++)
   begin : g_slv
      for (genvar k = 0; k < 2; k++)
      begin : g_fmt
         // rx slaves the tx counter alone, or both slave a shared master
         localparam logic ACTIVE = (SHARED || c == 1) && ((k == 0) ? HAS_W : HAS_N);
         ptf_sync_state_t st_q;
         logic [48:0] diff;
         logic [48:0] mag;
         logic far;
         logic lost_q;
         logic srst_n;
         logic ld;
         logic signed [1:0] tr;

         // master side on tx reset, slave side on its own path reset
         assign srst_n = nrst & link.tx_rst_n & ((c == 1) ? link.rx_rst_n : 1'b1);

         // master minus slave, in whole ns of this synchronizer's format only
         always_comb
         begin
            if (k == 0)
            begin
               diff = {17'h0, cnt_w[MI][47:16]} - {17'h0, cnt_w[c][47:16]};
               far = (cnt_w[MI][95:48] != cnt_w[c][95:48]);
            end
            else
            begin
               diff = {1'b0, cnt_n[MI][63:16]} - {1'b0, cnt_n[c][63:16]};
               far = 1'b0;
            end
            mag = diff[48] ? 49'(-diff) : diff;
            far = far | (mag > {1'b0, `PTF_LOCK_LIMIT_NS});
         end

         // hunt loads the master's time, track steers the slave period
         always_ff @(posedge sys_clk)
         begin
            if (!srst_n)
            begin
               st_q <= ptf_st_hunt;
               lost_q <= 1'b0;
            end
            else
            begin
               lost_q <= ACTIVE && tick[c] && st_q == ptf_st_track && far;
               if (ACTIVE && tick[c])
               begin
                  case (st_q)
                     ptf_st_hunt: st_q <= ptf_st_track;
                     ptf_st_track: st_q <= far ? ptf_st_hunt : ptf_st_track;
                     default: st_q <= ptf_st_hunt;
                  endcase
               end
            end
         end

         // load in hunt, otherwise one trim step toward the master
         assign ld = ACTIVE && tick[c] && st_q == ptf_st_hunt;
         assign tr = (!ACTIVE || st_q != ptf_st_track || diff == 49'h0) ? 2'sh0 :
            (diff[48] ? 2'sh3 : 2'sh1);
         if (k == 0)
         begin : g_w
            assign sld_w[c] = ld;
            assign str_w[c] = tr;
         end
         else
         begin : g_n
            assign sld_n[c] = ld;
            assign str_n[c] = tr;
         end
         assign sync_locked[c * 2 + k] = (st_q == ptf_st_track);
         assign sync_lock_lost[c * 2 + k] = lost_q;
      end
   end

   // core time inputs, only the configured layouts carry time
   assign link.core_tx_time_wide_in = HAS_W ? cnt_w[0] : `PTF_WIDE_RESET;
   assign link.core_tx_time_narrow_in = HAS_N ? cnt_n[0] : `PTF_NARROW_RESET;
   assign link.core_rx_time_wide_in = HAS_W ? cnt_w[1] : `PTF_WIDE_RESET;
   assign link.core_rx_time_narrow_in = HAS_N ? cnt_n[1] : `PTF_NARROW_RESET;
   assign master_time_wide = cnt_w[MI];
   assign master_time_narrow = cnt_n[MI];
endmodule // ptf_time_source

// ===== verification/ptf_link_props.sv
`timescale 1ns/1ps
`include "ptf_regs.svh"
module ptf_link_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // core side controls
   input wire logic tx_mac_tick,
   input wire logic rx_mac_tick,
   input wire logic csr_rst_n,
   // time values into the core
   input wire ptf_pkg::ptf_wide_t core_tx_time_wide_in,
   input wire ptf_pkg::ptf_narrow_t core_tx_time_narrow_in,
   input wire ptf_pkg::ptf_wide_t core_rx_time_wide_in,
   input wire ptf_pkg::ptf_narrow_t core_rx_time_narrow_in
);
   import ptf_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // a tick is followed by exactly three quiet cycles
   sequence tx_gap_s;
      !tx_mac_tick [*3] ##1 tx_mac_tick;
   endsequence
   sequence rx_gap_s;
      !rx_mac_tick [*3] ##1 rx_mac_tick;
   endsequence

   // mac period spacing
   tx_tick_gap_a: assert property (tx_mac_tick |=> tx_gap_s)
      else $error("tx tick spacing wrong");
   rx_tick_gap_a: assert property (rx_mac_tick |=> rx_gap_s)
      else $error("rx tick spacing wrong");
   // time only moves on its own path's tick
   tx_time_hold_a: assert property (csr_rst_n && !tx_mac_tick |=>
      $stable(core_tx_time_wide_in) && $stable(core_tx_time_narrow_in))
      else $error("tx time moved without tick");
   rx_time_hold_a: assert property (csr_rst_n && !rx_mac_tick |=>
      $stable(core_rx_time_wide_in) && $stable(core_rx_time_narrow_in))
      else $error("rx time moved without tick");
   // every tick brings a new value
   tx_time_fresh_a: assert property (tx_mac_tick && csr_rst_n |=>
      core_tx_time_narrow_in != $past(core_tx_time_narrow_in))
      else $error("tx time not refreshed at tick");
   rx_time_fresh_a: assert property (rx_mac_tick && csr_rst_n |=>
      core_rx_time_narrow_in != $past(core_rx_time_narrow_in))
      else $error("rx time not refreshed at tick");
   // general reset clears both counters
   csr_clear_a: assert property (!csr_rst_n |=> core_tx_time_wide_in == '0 &&
      core_rx_time_wide_in == '0 && core_tx_time_narrow_in == '0)
      else $error("time not cleared by csr reset");
   // wide layout keeps ns below one second
   ns_range_a: assert property (core_tx_time_wide_in[47:16] < `PTF_NS_PER_SEC &&
      core_rx_time_wide_in[47:16] < `PTF_NS_PER_SEC)
      else $error("wide ns field out of range");
   // tx master layouts share the fraction
   frac_pair_a: assert property (core_tx_time_wide_in[15:0] == core_tx_time_narrow_in[15:0])
      else $error("tx fraction differs between layouts");
endmodule // ptf_link_props

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
   import ptf_pkg::*;
   // clock, reset and user inputs
   logic sys_clk;
   logic nrst;
   logic csr_req_n, tx_req_n, rx_req_n;
   logic set_time;
   ptf_wide_t set_wide;
   ptf_narrow_t set_narrow;
   // observed outputs
   ptf_wide_t tx_wide, rx_wide, m_wide;
   ptf_narrow_t tx_narrow, rx_narrow, m_narrow, prev;
   logic tx_fresh, rx_fresh, tx_stuck, rx_stuck, lost_seen;
   logic [3:0] locked, lost;
   int n_fail, samples_checked;

   // both ends joined through the link
   ptf_time_if u_ptf_time_if ();
   ptf_time_source u_ptf_time_source (.sys_clk(sys_clk), .nrst(nrst), .link(u_ptf_time_if),
      .set_time(set_time), .set_wide(set_wide), .set_narrow(set_narrow),
      .sync_locked(locked), .sync_lock_lost(lost),
      .master_time_wide(m_wide), .master_time_narrow(m_narrow));
   ptf_mac_time_port u_ptf_mac_time_port (.sys_clk(sys_clk), .nrst(nrst), .link(u_ptf_time_if),
      .csr_rst_req_n(csr_req_n), .tx_rst_req_n(tx_req_n), .rx_rst_req_n(rx_req_n),
      .tx_time_wide(tx_wide), .tx_time_narrow(tx_narrow), .rx_time_wide(rx_wide),
      .rx_time_narrow(rx_narrow), .tx_time_fresh(tx_fresh), .rx_time_fresh(rx_fresh),
      .tx_time_stuck(tx_stuck), .rx_time_stuck(rx_stuck));
   ptf_link_props u_ptf_link_props (.sys_clk(sys_clk), .nrst(nrst),
      .tx_mac_tick(u_ptf_time_if.tx_mac_tick), .rx_mac_tick(u_ptf_time_if.rx_mac_tick),
      .csr_rst_n(u_ptf_time_if.csr_rst_n),
      .core_tx_time_wide_in(u_ptf_time_if.core_tx_time_wide_in),
      .core_tx_time_narrow_in(u_ptf_time_if.core_tx_time_narrow_in),
      .core_rx_time_wide_in(u_ptf_time_if.core_rx_time_wide_in),
      .core_rx_time_narrow_in(u_ptf_time_if.core_rx_time_narrow_in));

   // 100 mhz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // advance n edges, then settle
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // compare and count
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // next core sample strobe on the tx path
   task automatic wait_fresh();
      for (int i = 0; i < 20; i++)
      begin
         step(1);
         if (tx_fresh === 1'b1)
            break;
      end
      check(tx_fresh, 1'b1);
   endtask

   // wait for a lock pattern, bounded
   task automatic poll_locked(input logic [3:0] want);
      for (int i = 0; i < 60; i++)
      begin
         if (locked === want)
            break;
         step(1);
      end
   endtask

   // two samples one period apart differ by 40 ns
   task automatic t_advance();
      wait_fresh();
      prev = tx_narrow;
      wait_fresh();
      check(tx_narrow - prev, 64'h0000_0000_0028_0000);
      check(rx_fresh, 1'b1);
      check(rx_narrow - prev, 64'h0000_0000_0028_0000);
      check(tx_stuck, 1'b0);
      check(rx_stuck, 1'b0);
      $display("test advance done");
   endtask

   // master jump across a second boundary, rx slave follows
   task automatic t_set();
      set_wide = {48'h5, 32'h3b9ac9ec, 16'h0};
      set_narrow = {48'h1000, 16'h0};
      set_time = 1'b1;
      step(1);
      set_time = 1'b0;
      for (int i = 0; i < 12 && m_wide[95:48] !== 48'h6; i++)
         step(1);
      check(m_wide, {48'h6, 32'h14, 16'h0});
      check(m_narrow, 64'h0000_0000_1028_0000);
      lost_seen = 1'b0;
      for (int i = 0; i < 60; i++)
      begin
         step(1);
         lost_seen = lost_seen | lost[2];
         if (rx_wide[95:48] === 48'h6 && locked === 4'hc)
            break;
      end
      check(lost_seen, 1'b1);
      check(rx_wide[95:48], 48'h6);
      check(locked, 4'hc);
      wait_fresh();
      check(tx_wide[95:48], 48'h6);
      $display("test set done");
   endtask

   // one path reset drops the syncs, tx keeps counting
   task automatic t_path_reset(input bit on_rx);
      if (on_rx)
         rx_req_n = 1'b0;
      else
         tx_req_n = 1'b0;
      poll_locked(4'h0);
      check(locked, 4'h0);
      // tx core samples sit in reset too on a tx request, so watch the master counter
      prev = m_narrow;
      step(4);
      check(m_narrow - prev, 64'h0000_0000_0028_0000);
      rx_req_n = 1'b1;
      tx_req_n = 1'b1;
      poll_locked(4'hc);
      check(locked, 4'hc);
      $display("test path reset done");
   endtask

   // general reset clears both counters
   task automatic t_csr();
      csr_req_n = 1'b0;
      for (int i = 0; i < 10 && u_ptf_time_if.csr_rst_n !== 1'b0; i++)
         step(1);
      step(2);
      check(m_wide, 96'h0);
      check(u_ptf_time_if.core_rx_time_wide_in, 96'h0);
      wait_fresh();
      check(tx_wide, 96'h0);
      csr_req_n = 1'b1;
      step(10);
      wait_fresh();
      prev = tx_narrow;
      wait_fresh();
      check(tx_narrow - prev, 64'h0000_0000_0028_0000);
      $display("test csr reset done");
   endtask

   // verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      nrst = 1'b0;
      csr_req_n = 1'b1;
      tx_req_n = 1'b1;
      rx_req_n = 1'b1;
      set_time = 1'b0;
      set_wide = '0;
      set_narrow = '0;
      n_fail = 0;
      samples_checked = 0;
      repeat (2) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      step(30);
      t_advance();
      t_set();
      t_path_reset(1'b1);
      t_path_reset(1'b0);
      t_csr();
      tally_and_finish();
   end

   // hang guard, far beyond the expected run
   initial
   begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule // tb
